// [hw/pin_mux_pkg.sv]
// Functional notes
// - Strap selects pin a: gpio20 or read strobe
// - Strap selects pin b: gpio21 or oe/row strobe
// - Selection takes effect only at reset release
// - GPIO role pins are inputs after reset
// - Strobes float in reset, then drive 1
// - Pin a carries read/address/column/sync-read strobe
// - Pin b carries output-enable or row strobe
// - Pins float while hold grants bus away
// - Hold clock toggles in memory role unless float bit set; clocks float in GPIO role
// - Pins float in off mode
// - Bus holders on by default, software controlled
package pin_mux_pkg;
    // Register byte offsets on the Avalon-MM slave
    localparam logic [3:0] OFS_BUS_CTRL    = 4'h0;  // External bus control register
    localparam logic [3:0] OFS_MEM_CTRL    = 4'h4;  // Memory global control (clock float bits)
    localparam logic [3:0] OFS_CE_CTRL     = 4'h8;  // Chip-enable secondary control 1
    localparam logic [3:0] OFS_GPIO_CTRL   = 4'hC;  // GPIO direction and output data
    // Field positions
    localparam int BIT_HOLDER_A      = 0;  // Bus holder enable, pin a
    localparam int BIT_HOLDER_B      = 1;  // Bus holder enable, pin b
    localparam int BIT_STRAP_STATUS  = 8;  // Latched strap (read only)
    localparam int BIT_CLK_FLOAT_0   = 0;  // Hold clock float, clock 0
    localparam int BIT_CLK_FLOAT_1   = 1;  // Hold clock float, clock 1
    localparam int BIT_SYNC_RD_SEL   = 0;  // Sync read enable select
    localparam int BIT_DIR_A         = 0;  // GPIO direction pin a, 1 = output
    localparam int BIT_DIR_B         = 1;  // GPIO direction pin b
    localparam int BIT_DOUT_A        = 4;  // GPIO output data pin a
    localparam int BIT_DOUT_B        = 5;  // GPIO output data pin b
    // Reset values
    localparam logic [1:0] RST_HOLDER    = 2'h3;  // Holders enabled by default
    localparam logic [1:0] RST_CLK_FLOAT = 2'h0;  // Clocks keep running in hold
    localparam logic       RST_SYNC_RD   = 1'b0;
    localparam logic [1:0] RST_GPIO_DIR  = 2'h0;  // All inputs
    localparam logic [1:0] RST_GPIO_DOUT = 2'h0;
    // Memory types steering the strobe roles
    typedef enum logic [1:0] {
        MEM_ASYNC = 2'h0,
        MEM_SYNC  = 2'h1,
        MEM_SDRAM = 2'h2
    } mem_type_e;
    localparam int NUM_CLK_OUT = 2;  // Memory clock outputs
endpackage

// [hw/pin_drive_if.sv]
`timescale 1ns/1ps
`default_nettype none
// One pad's drive request and its resolved result
interface pin_drive_if;
    logic req_oe;   // Core wants to drive
    logic req_out;  // Core drive level
    logic floated;  // Forced float (reset, hold, off)
    logic pad_oe;   // Resolved output enable
    logic pad_out;  // Resolved output level
    modport core (output req_oe, output req_out, output floated, input pad_oe, input pad_out);
    modport pad  (input req_oe, input req_out, input floated, output pad_oe, output pad_out);
endinterface
`default_nettype wire

// [hw/pin_pad_ctl.sv]
`timescale 1ns/1ps
`default_nettype none
// Output stage of one pad: forced float overrides any drive request
module pin_pad_ctl (
    pin_drive_if.pad p
);
    // Float wins so hold, off and reset can never be overridden by core logic
    assign p.pad_oe  = p.req_oe & ~p.floated;
    assign p.pad_out = p.req_out;
endmodule
`default_nettype wire

// [hw/parallel_port_control_pin_mux.sv]
// Decided for this implementation: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module parallel_port_control_pin_mux
    import pin_mux_pkg::*;
(
    input  wire logic        i_mclk,                    // 20 MHz core clock
    input  wire logic        i_rst_b,                   // Sync reset, active low
    input  wire logic        i_boot_function_strap,     // Strap level
    input  wire logic        i_hold_b,                  // Hold request, active low
    input  wire logic        i_trst_b,                  // Test reset, active low
    input  wire logic        i_emulation_pin_zero,      // Emulation pin 0
    input  wire logic        i_emulation_off_pin,       // Emulation 1 / off pin
    input  wire logic [1:0]  i_mem_type,                // Memory type being accessed
    input  wire logic        i_mem_rd_strobe,           // Read strobe level from memory core
    input  wire logic        i_mem_addr_strobe,         // Sync address strobe level
    input  wire logic        i_mem_col_strobe,          // SDRAM column strobe level
    input  wire logic        i_mem_oe_strobe,           // Output-enable strobe level
    input  wire logic        i_mem_row_strobe,          // SDRAM row strobe level
    input  wire logic [1:0]  i_mem_clk,                 // Memory clocks to pass out
    input  wire logic        i_ctrl_pin_a,              // Pad a input
    input  wire logic        i_ctrl_pin_b,              // Pad b input
    output logic             o_ctrl_pin_a,              // Pad a output
    output logic             o_ctrl_pin_a_oe,           // Pad a output enable
    output logic             o_ctrl_pin_b,              // Pad b output
    output logic             o_ctrl_pin_b_oe,           // Pad b output enable
    output logic [1:0]       o_holder_en,               // Bus holder enables a, b
    output logic [1:0]       o_mem_clock_out,           // Memory clocks
    output logic [1:0]       o_mem_clock_out_oe,        // Memory clock enables
    output logic             o_port_io_bit_twenty,      // GPIO 20 input value
    output logic             o_port_io_bit_twentyone,   // GPIO 21 input value
    output logic             o_mem_function_sel,        // 1 = memory role latched
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,               // Byte address
    input  wire logic        avs_read,                  // Read request
    input  wire logic        avs_write,                 // Write request
    input  wire logic [31:0] avs_writedata,             // Write data
    input  wire logic [3:0]  avs_byteenable,            // Byte enables
    output logic [31:0]      avs_readdata,              // Read data
    output logic             avs_waitrequest            // Stall
);
    // Control state
    logic       strap_r;          // Latched strap: 1 = memory strobes
    logic       in_reset_r;       // Registered reset, marks release edge
    logic [1:0] holder_r;         // Bus holder enables
    logic [1:0] clk_float_r;      // Hold clock float bits
    logic       sync_rd_r;        // Sync read-enable select
    logic [1:0] gpio_dir_r;       // GPIO directions
    logic [1:0] gpio_dout_r;      // GPIO output data
    logic       ack_r;            // Bus answer phase
    logic [31:0] rdata_r;         // Registered read data
    logic       hold_act;         // Bus granted away
    logic       off_act;          // Off (test) mode
    logic       reset_act;        // Reset asserted
    logic       strobe_a;         // Selected strobe level pin a
    logic       strobe_b;         // Selected strobe level pin b
    logic       req_fire;         // Bus access accepted this cycle

    assign reset_act = ~i_rst_b;
    assign hold_act  = ~i_hold_b;
    // Off mode needs all three test pins in their off levels
    assign off_act   = ~i_trst_b & i_emulation_pin_zero & ~i_emulation_off_pin;

    // Strap captured once, in the first clock after reset release
    // Capture uses the clock, never the async path, so the latch is a plain flop
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            in_reset_r <= 1'b1;
            strap_r    <= 1'b0;
        end else begin
            in_reset_r <= 1'b0;
            if (in_reset_r) begin
                strap_r <= i_boot_function_strap;
            end
        end
    end
    // Role shown only after release; during reset the pads are floated anyway
    assign o_mem_function_sel = strap_r;

    // Strobe role for pin a: sync memories pick read enable or address strobe
    always_comb begin
        strobe_a = i_mem_rd_strobe;
        strobe_b = i_mem_oe_strobe;
        unique case (mem_type_e'(i_mem_type))
            MEM_ASYNC: begin
                strobe_a = i_mem_rd_strobe;
                strobe_b = i_mem_oe_strobe;
            end
            MEM_SYNC: begin
                strobe_a = sync_rd_r ? i_mem_rd_strobe : i_mem_addr_strobe;
                strobe_b = i_mem_oe_strobe;
            end
            MEM_SDRAM: begin
                strobe_a = i_mem_col_strobe;
                strobe_b = i_mem_row_strobe;
            end
            default: begin
                // Unused code leaves strobes inactive high
                strobe_a = 1'b1;
                strobe_b = 1'b1;
            end
        endcase
    end

    // Pad stages
    pin_drive_if pa ();
    pin_drive_if pb ();

    // Memory role drives strobe (idle 1); GPIO role follows direction register
    assign pa.req_oe  = strap_r | gpio_dir_r[BIT_DIR_A];
    assign pa.req_out = strap_r ? strobe_a : gpio_dout_r[BIT_DIR_A];
    assign pb.req_oe  = strap_r | gpio_dir_r[BIT_DIR_B];
    assign pb.req_out = strap_r ? strobe_b : gpio_dout_r[BIT_DIR_B];
    // Reset, hold and off all float the pads
    assign pa.floated = reset_act | in_reset_r | hold_act | off_act;
    assign pb.floated = reset_act | in_reset_r | hold_act | off_act;

    pin_pad_ctl u_pad_a (.p(pa));
    pin_pad_ctl u_pad_b (.p(pb));

    assign o_ctrl_pin_a    = pa.pad_out;
    assign o_ctrl_pin_a_oe = pa.pad_oe;
    assign o_ctrl_pin_b    = pb.pad_out;
    assign o_ctrl_pin_b_oe = pb.pad_oe;
    // GPIO inputs always read the pad level
    assign o_port_io_bit_twenty    = i_ctrl_pin_a;
    assign o_port_io_bit_twentyone = i_ctrl_pin_b;

    // Memory clocks: in memory role float in hold only when the float bit asks; GPIO role and off mode float all
    genvar g;
    generate
        for (g = 0; g < NUM_CLK_OUT; g++) begin : g_clk
            assign o_mem_clock_out[g]    = i_mem_clk[g];
            assign o_mem_clock_out_oe[g] = strap_r & ~off_act & ~(hold_act & clk_float_r[g]);
        end
    endgenerate

    assign o_holder_en = holder_r;

    // Bus slave: one wait state, answer on the second cycle
    assign req_fire        = (avs_read | avs_write) & ~ack_r;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign avs_readdata    = rdata_r;

    // Answer phase flop
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req_fire;
        end
    end

    // Register writes take effect at the edge waitrequest is low
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            holder_r    <= RST_HOLDER;
            clk_float_r <= RST_CLK_FLOAT;
            sync_rd_r   <= RST_SYNC_RD;
            gpio_dir_r  <= RST_GPIO_DIR;
            gpio_dout_r <= RST_GPIO_DOUT;
        end else if (avs_write && ack_r && avs_byteenable[0]) begin
            unique case (avs_address)
                OFS_BUS_CTRL:  holder_r    <= avs_writedata[1:0];
                OFS_MEM_CTRL:  clk_float_r <= avs_writedata[1:0];
                OFS_CE_CTRL:   sync_rd_r   <= avs_writedata[BIT_SYNC_RD_SEL];
                OFS_GPIO_CTRL: begin
                    gpio_dir_r  <= avs_writedata[1:0];
                    gpio_dout_r <= avs_writedata[BIT_DOUT_B:BIT_DOUT_A];
                end
                default: begin
                    // Unmapped writes are dropped
                end
            endcase
        end
    end

    // Read data captured in the wait cycle, stands at the answer edge
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_read && !ack_r) begin
            rdata_r <= 32'h0000_0000;
            unique case (avs_address)
                OFS_BUS_CTRL: begin
                    rdata_r[1:0]             <= holder_r;
                    rdata_r[BIT_STRAP_STATUS] <= strap_r;
                end
                OFS_MEM_CTRL:  rdata_r[1:0] <= clk_float_r;
                OFS_CE_CTRL:   rdata_r[BIT_SYNC_RD_SEL] <= sync_rd_r;
                OFS_GPIO_CTRL: begin
                    rdata_r[1:0]                  <= gpio_dir_r;
                    rdata_r[BIT_DOUT_B:BIT_DOUT_A] <= gpio_dout_r;
                end
                default: begin
                    // Unmapped reads return zero
                end
            endcase
        end
    end

    // Checks
    // Pad and off-mode float checks carry no disable so they also cover the reset cycles

    // Pad a must stay released for the whole reset
    a_reset_floats_a: assert property (@(posedge i_mclk)
        !i_rst_b |=> !o_ctrl_pin_a_oe)
        else $error("pin a driven in reset");

    // Pad b must stay released for the whole reset
    a_reset_floats_b: assert property (@(posedge i_mclk)
        !i_rst_b |=> !o_ctrl_pin_b_oe)
        else $error("pin b driven in reset");

    // Release cycle still floats: the new role is not valid yet
    a_release_floats: assert property (@(posedge i_mclk)
        in_reset_r |-> !o_ctrl_pin_a_oe && !o_ctrl_pin_b_oe)
        else $error("pin driven in release cycle");

    // Strap moves after capture must not reach the role
    a_strap_held: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        !in_reset_r |=> $stable(strap_r))
        else $error("strap changed after capture");

    // Role is the strap level seen at the release edge
    a_strap_capture: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        in_reset_r |=> strap_r == $past(i_boot_function_strap))
        else $error("strap not captured at release");

    // Hold hands the bus away: pad a must let go
    a_hold_floats_a: assert property (@(posedge i_mclk)
        hold_act |-> !o_ctrl_pin_a_oe)
        else $error("pin a driven during hold");

    // Hold hands the bus away: pad b must let go
    a_hold_floats_b: assert property (@(posedge i_mclk)
        hold_act |-> !o_ctrl_pin_b_oe)
        else $error("pin b driven during hold");

    // Off mode releases both control pads
    a_off_floats_a: assert property (@(posedge i_mclk)
        off_act |-> !o_ctrl_pin_a_oe && !o_ctrl_pin_b_oe)
        else $error("pin driven in off mode");

    // Off mode also releases the memory clocks
    a_off_clk_float: assert property (@(posedge i_mclk)
        off_act |-> o_mem_clock_out_oe == 2'h0)
        else $error("clock driven in off mode");

    // Memory role with nothing overriding drives pad a
    a_mem_drives_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        strap_r && !in_reset_r && !hold_act && !off_act |-> o_ctrl_pin_a_oe)
        else $error("memory strobe a not driven");

    // Memory role with nothing overriding drives pad b
    a_mem_drives_b: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        strap_r && !in_reset_r && !hold_act && !off_act |-> o_ctrl_pin_b_oe)
        else $error("memory strobe b not driven");

    // Strobes start driving after the first edge after release, checked on the second edge
    a_idle_drive: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        $rose(i_rst_b) ##1 strap_r && !hold_act && !off_act |-> o_ctrl_pin_a_oe && o_ctrl_pin_b_oe)
        else $error("strobes not driven after release");

    // GPIO role comes up as an input on pad a
    a_gpio_input_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        $rose(i_rst_b) ##0 !strap_r [*2] |-> !o_ctrl_pin_a_oe)
        else $error("gpio pin a not input after reset");

    // GPIO role comes up as an input on pad b
    a_gpio_input_b: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        $rose(i_rst_b) ##0 !strap_r [*2] |-> !o_ctrl_pin_b_oe)
        else $error("gpio pin b not input after reset");

    // Clocks have no meaning in the GPIO role, so they stay released
    a_clk_gpio_off: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        !strap_r |-> o_mem_clock_out_oe == 2'h0)
        else $error("clock driven in gpio role");

    // Float bit set: clock 0 released in hold
    a_clk_float: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        hold_act && clk_float_r[0] |-> !o_mem_clock_out_oe[0])
        else $error("clock 0 not floated in hold");

    // Float bit set: clock 1 released in hold
    a_clk_float_one: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        hold_act && clk_float_r[1] |-> !o_mem_clock_out_oe[1])
        else $error("clock 1 not floated in hold");

    // Float bit clear: clock 0 keeps running through hold
    a_clk_runs_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        hold_act && strap_r && !off_act && !clk_float_r[0] |-> o_mem_clock_out_oe[0])
        else $error("clock 0 stopped in hold");

    // Float bit clear: clock 1 keeps running through hold
    a_clk_runs: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        hold_act && strap_r && !off_act && !clk_float_r[1] |-> o_mem_clock_out_oe[1])
        else $error("clock 1 stopped in hold");

    // Holders come out of reset enabled
    a_holder_dflt: assert property (@(posedge i_mclk)
        !i_rst_b |=> o_holder_en == RST_HOLDER)
        else $error("holders not enabled at reset");

    // A completed control write reaches the holder enables
    a_holder_write: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        avs_write && ack_r && avs_byteenable[0] && avs_address == OFS_BUS_CTRL |=>
        o_holder_en == $past(avs_writedata[1:0]))
        else $error("holder write lost");

    // Async memories take the read enable on pad a
    a_async_rd: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        i_mem_type == MEM_ASYNC |-> strobe_a == i_mem_rd_strobe)
        else $error("async read strobe wrong");

    // Sync memories with select set take the read enable
    a_sync_rd_sel: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        i_mem_type == MEM_SYNC && sync_rd_r |-> strobe_a == i_mem_rd_strobe)
        else $error("sync read enable wrong");

    // Sync memories with select clear take the address strobe
    a_sync_addr: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        i_mem_type == MEM_SYNC && !sync_rd_r |-> strobe_a == i_mem_addr_strobe)
        else $error("sync address strobe wrong");

    // Sync memories take the output enable on pad b
    a_sync_oe: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        i_mem_type == MEM_SYNC |-> strobe_b == i_mem_oe_strobe)
        else $error("sync oe strobe wrong");

    // SDRAM takes column on pad a and row on pad b
    a_sdram_col: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        i_mem_type == MEM_SDRAM |-> strobe_a == i_mem_col_strobe && strobe_b == i_mem_row_strobe)
        else $error("sdram strobe roles wrong");

    // Async output enable reaches pad b when driven
    a_async_oe: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        i_mem_type == MEM_ASYNC && strap_r && o_ctrl_pin_b_oe |-> o_ctrl_pin_b == i_mem_oe_strobe)
        else $error("oe strobe not on pin b");

    // Selected strobe reaches pad a when driven
    a_strobe_on_pin: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        strap_r && o_ctrl_pin_a_oe |-> o_ctrl_pin_a == strobe_a)
        else $error("strobe not on pin a");
endmodule
`default_nettype wire

// [test/mem_side_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Far side of the two control pads: memory devices plus board wiring
module mem_side_model (
    input  wire logic       i_mclk,      // Core clock
    input  wire logic [1:0] i_pad_oe,    // Device drive enables b, a
    input  wire logic [1:0] i_pad_out,   // Device drive levels b, a
    input  wire logic [1:0] i_holder_en, // Bus holders b, a
    input  wire logic [1:0] i_drive_en,  // Far side drives the pad
    input  wire logic [1:0] i_drive_lvl, // Far side drive level
    output logic      [1:0] o_pad_lvl    // Resolved wire level
);
    logic [1:0] last_r; // Last resolved level, kept by the holder

    // Released pad: holder keeps the level, otherwise it wanders each cycle
    // so a stale value can never pass as a real input
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (i_pad_oe[i]) begin
                o_pad_lvl[i] = i_pad_out[i];
            end else if (i_drive_en[i]) begin
                o_pad_lvl[i] = i_drive_lvl[i];
            end else begin
                o_pad_lvl[i] = i_holder_en[i] ? last_r[i] : ~last_r[i];
            end
        end
    end

    // Remember the wire level for the holder
    always_ff @(posedge i_mclk) begin
        last_r <= (o_pad_lvl === 2'bxx) ? 2'h0 : o_pad_lvl;
    end
endmodule
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pin_mux_pkg::*;
    typedef struct packed {logic [1:0] mt; logic sel; logic [4:0] stb; logic hold_b; logic [3:0] exp;} row_s;
    logic        i_mclk = 1'b0, i_rst_b = 1'b0, strap = 1'b1, hold_b = 1'b1;
    logic        trst_b = 1'b1, emulation_pin_zero = 1'b0, offp = 1'b1, rd = 1'b0, wr = 1'b0;
    logic [1:0]  mt = 2'h0, mclk = 2'h1, drv_en = 2'h0, drv_lvl = 2'h0, pad_lvl, holder, ck, ckoe;
    logic [4:0]  stb = 5'h1F;      // {rd, addr, col, oe, row}, idle high
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic        a, aoe, b, boe, g20, g21, fsel, wreq;
    int          err_count = 0, checked = 0, cycles = 0;
    // Strobe routing cases: {aoe, a, boe, b} per memory type and select
    row_s rows [10] = '{'{2'h0,1'b0,5'h0F,1'b1,4'hB}, '{2'h0,1'b0,5'h1D,1'b1,4'hE},
        '{2'h1,1'b0,5'h17,1'b1,4'hB}, '{2'h1,1'b1,5'h17,1'b1,4'hF}, '{2'h1,1'b1,5'h0F,1'b1,4'hB},
        '{2'h1,1'b0,5'h1D,1'b1,4'hE}, '{2'h2,1'b0,5'h1B,1'b1,4'hB}, '{2'h2,1'b0,5'h1E,1'b1,4'hE},
        '{2'h3,1'b0,5'h00,1'b1,4'hF}, '{2'h0,1'b0,5'h1F,1'b0,4'h0}};

    always #25 i_mclk = ~i_mclk;
    // Memory clocks toggle every cycle, out of phase with each other
    always @(posedge i_mclk) mclk <= ~mclk;
    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            complete_run();
        end
    end

    parallel_port_control_pin_mux dut_u (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
        .i_boot_function_strap(strap), .i_hold_b(hold_b), .i_trst_b(trst_b),
        .i_emulation_pin_zero(emulation_pin_zero), .i_emulation_off_pin(offp), .i_mem_type(mt),
        .i_mem_rd_strobe(stb[4]), .i_mem_addr_strobe(stb[3]), .i_mem_col_strobe(stb[2]),
        .i_mem_oe_strobe(stb[1]), .i_mem_row_strobe(stb[0]), .i_mem_clk(mclk),
        .i_ctrl_pin_a(pad_lvl[0]), .i_ctrl_pin_b(pad_lvl[1]), .o_ctrl_pin_a(a),
        .o_ctrl_pin_a_oe(aoe), .o_ctrl_pin_b(b), .o_ctrl_pin_b_oe(boe), .o_holder_en(holder),
        .o_mem_clock_out(ck), .o_mem_clock_out_oe(ckoe), .o_port_io_bit_twenty(g20),
        .o_port_io_bit_twentyone(g21), .o_mem_function_sel(fsel), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hF),
        .avs_readdata(rdata), .avs_waitrequest(wreq));

    mem_side_model far_u (.i_mclk(i_mclk), .i_pad_oe({boe, aoe}), .i_pad_out({b, a}),
        .i_holder_en(holder), .i_drive_en(drv_en), .i_drive_lvl(drv_lvl), .o_pad_lvl(pad_lvl));

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One Avalon-MM transfer: raised after a rising edge, held until waitrequest is seen low at one
    task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge i_mclk);
        adr <= ad;
        wdata <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge i_mclk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        r = rdata;
        if (n >= 20) err_count++;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    // Reset with a given strap, checking pads around the release
    task automatic do_reset(input logic s);
        @(posedge i_mclk);
        i_rst_b <= 1'b0;
        strap <= s;
        repeat (8) @(posedge i_mclk);
        @(negedge i_mclk);
        chk({aoe, boe}, 2'h0);
        @(posedge i_mclk);
        i_rst_b <= 1'b1;
        @(negedge i_mclk);
        chk({aoe, boe}, 2'h0);
        repeat (2) @(posedge i_mclk);
        @(negedge i_mclk);
        chk({aoe, boe, fsel, ckoe}, {5{s}});
        if (s) chk({a, b}, 2'h3);
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        do_reset(1'b1);
        bus(1'b0, OFS_BUS_CTRL, 32'h0, q);
        chk({q[8], q[1:0], holder}, 5'h1F);
        bus(1'b1, OFS_BUS_CTRL, 32'h0, q);
        @(negedge i_mclk);
        chk(holder, 2'h0);
        bus(1'b1, OFS_BUS_CTRL, 32'h3, q);
        $display("Test reset and holders done");
        // Strobe routing table
        foreach (rows[i]) begin
            bus(1'b1, OFS_CE_CTRL, {31'h0, rows[i].sel}, q);
            mt <= rows[i].mt;
            stb <= rows[i].stb;
            hold_b <= rows[i].hold_b;
            @(negedge i_mclk);
            chk(rows[i].hold_b ? {aoe, a, boe, b} : {aoe, 1'b0, boe, 1'b0}, rows[i].exp);
        end
        @(posedge i_mclk);
        hold_b <= 1'b1;
        $display("Test strobe table done");
        // Strap moves after release: assignment must not follow
        strap <= 1'b0;
        repeat (3) @(posedge i_mclk);
        @(negedge i_mclk);
        chk({fsel, aoe}, 2'h3);
        // Hold with one clock floated, the other running
        @(posedge i_mclk);
        hold_b <= 1'b0;
        bus(1'b1, OFS_MEM_CTRL, 32'h1, q);
        @(negedge i_mclk);
        chk({ckoe, ck[1], aoe, boe}, {2'h2, mclk[1], 2'h0});
        bus(1'b1, OFS_MEM_CTRL, 32'h2, q);
        @(negedge i_mclk);
        chk({ckoe, ck}, {2'h1, mclk});
        @(posedge i_mclk);
        hold_b <= 1'b1;
        $display("Test hold done");
        // Off mode needs all three pins; two of three is not enough
        @(posedge i_mclk);
        trst_b <= 1'b0;
        emulation_pin_zero <= 1'b1;
        @(negedge i_mclk);
        chk({aoe, boe}, 2'h3);
        @(posedge i_mclk);
        offp <= 1'b0;
        @(negedge i_mclk);
        chk({aoe, boe, ckoe}, 4'h0);
        @(posedge i_mclk);
        trst_b <= 1'b1;
        offp <= 1'b1;
        $display("Test off mode done");
        // General-purpose role
        do_reset(1'b0);
        @(posedge i_mclk);
        drv_en <= 2'h3;
        drv_lvl <= 2'h2;
        @(negedge i_mclk);
        chk({g21, g20}, 2'h2);
        @(posedge i_mclk);
        drv_en <= 2'h0;
        bus(1'b1, OFS_GPIO_CTRL, 32'h23, q);
        @(negedge i_mclk);
        chk({aoe, a, boe, b}, 4'hB);
        bus(1'b0, OFS_GPIO_CTRL, 32'h0, q);
        chk(q, 32'h23);
        $display("Test gpio role done");
        complete_run();
    end
endmodule
`default_nettype wire
